// ---- rtl/hwd_defs.svh ----
/*
 Constants for the two-mode hardware watchdog: register offsets,
 field positions, reset values and timing counts.
 Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef HWD_DEFS_SVH
`define HWD_DEFS_SVH

`define HWD_OFS_SERVICE   8'h00
`define HWD_OFS_CTRL      8'h04
`define HWD_OFS_PERIOD    8'h08
`define HWD_OFS_STATUS    8'h0C
`define HWD_OFS_IRQ_STAT  8'h10
`define HWD_OFS_IRQ_MASK  8'h14
`define HWD_OFS_COUNT     8'h18

// Control fields
`define HWD_CTRL_EVT_LSB  0
`define HWD_CTRL_SAFE_BIT 2

// Status fields
`define HWD_ST_SAFE_BIT   0
`define HWD_ST_RUN_BIT    1
`define HWD_ST_OVR_BIT    2

// Interrupt status fields
`define HWD_IRQ_EXPIRE    0
`define HWD_IRQ_BADSVC    1

`define HWD_SERVICE_KEY   32'hA55A_5AA5
`define HWD_PERIOD_RST    32'h0016_E360

`define HWD_CLK_HZ        50000000
`define HWD_RECOVER_US    250
`define HWD_RECOVER_CYC   ((`HWD_RECOVER_US * (`HWD_CLK_HZ / 1000000)))

`endif

// ---- rtl/hwd_pkg.sv ----
/*
 Types for the two-mode hardware watchdog.
 Assumes the constants of hwd_defs.svh.
*/
package hwd_pkg;
	// Action taken on expiry; off disables the watchdog
	typedef enum logic [1:0]
	{
		HWD_EVT_OFF   = 2'b00,
		HWD_EVT_IRQ   = 2'b01,
		HWD_EVT_RESET = 2'b10,
		HWD_EVT_BOTH  = 2'b11
	} hwd_event_e;

	typedef enum logic [1:0]
	{
		HWD_IDLE    = 2'b00,
		HWD_RUN     = 2'b01,
		HWD_RECOVER = 2'b11
	} hwd_state_e;
endpackage

// ---- rtl/hwd_watchdog.sv ----
/*
 Two-mode hardware watchdog with an AXI4-Lite register slave.
 Assumes one 50 MHz clock, an active-low asynchronous reset and a
 processor that services by writing a fixed key word.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
// Contract
// - Period elapsing without valid service triggers the configured event.
// - Two modes exist: locked safety mode and reduced-safety flexible mode.
// - In flexible mode event, period and mode can change at runtime.
// - Event setting chooses expiry action; one setting disables the watchdog.
// - Safety mode keeps chosen settings; later changes and exits are refused.
// - After power-up: flexible mode, watchdog disabled.
// - Expiry can be configured to raise a processor interrupt.
// - Interrupt can be polled or routed to the interrupt controller.
// - Interrupt stays latched until the processor acknowledges it.
// - Interrupt mask gates propagation only, not timer or latch.
// - After expiry, recovery lasts 250 us then a new cycle starts.
// - Valid service during recovery ends it and restarts the cycle.
`timescale 1ns/1ps
`default_nettype none
`include "hwd_defs.svh"

module hwd_watchdog #(
	parameter int unsigned RECOVER_CYC = `HWD_RECOVER_CYC
)(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	output logic             wdt_reset_req
);
	logic              rst_s1_q;
	logic              rst_n;
	logic              aw_held_q;
	logic [7:0]        awaddr_q;
	logic              w_held_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              wr_go;
	logic              wr_ok;
	logic              rd_go;
	hwd_pkg::hwd_event_e evt_q;
	logic              safe_q;
	logic [31:0]       period_q;
	hwd_pkg::hwd_state_e state_q;
	logic [31:0]       cnt_q;
	logic [1:0]        ist_q;
	logic [1:0]        imask_q;
	logic              svc_good;
	logic              svc_bad;
	logic              expire;
	logic              cfg_wr;
	logic [31:0]       rd_d;
	logic              rd_ok;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// Write channel: address and data taken in either order
	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_ok = awaddr_q[1:0] == 2'b00 && awaddr_q <= `HWD_OFS_COUNT;

	// Address half; held until the pair is consumed
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_q     <= 1'b0;
			awaddr_q      <= 8'h00;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_q <= s_axi_awaddr;
			end
			if (wr_go)
			begin
				aw_held_q <= 1'b0;
			end
			else if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
			end
		end
	end

	// Data half; strobes kept so a torn word can be told apart
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			w_held_q     <= 1'b0;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				w_held_q <= 1'b0;
			end
			else if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
			end
		end
	end

	// Response follows both halves and stands until taken
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Full-word writes only for service, so a torn key never counts
	assign svc_good = wr_go && awaddr_q == `HWD_OFS_SERVICE
		&& wstrb_q == 4'hF && wdata_q == `HWD_SERVICE_KEY;
	assign svc_bad = wr_go && awaddr_q == `HWD_OFS_SERVICE && !svc_good;
	assign cfg_wr = wr_go && !safe_q && wstrb_q[0];
	// A good service on the last count wins over expiry
	assign expire = state_q == hwd_pkg::HWD_RUN && cnt_q == 32'h0000_0000
		&& !svc_good;

	// Configuration and mode
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			evt_q    <= hwd_pkg::HWD_EVT_OFF;
			safe_q   <= 1'b0;
			period_q <= `HWD_PERIOD_RST;
		end
		else if (cfg_wr)
		begin
			if (awaddr_q == `HWD_OFS_CTRL)
			begin
				evt_q  <= hwd_pkg::hwd_event_e'(
					wdata_q[`HWD_CTRL_EVT_LSB +: 2]);
				safe_q <= wdata_q[`HWD_CTRL_SAFE_BIT];
			end
			else if (awaddr_q == `HWD_OFS_PERIOD && wstrb_q == 4'hF)
			begin
				period_q <= wdata_q;
			end
		end
	end

	// Timer state machine
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= hwd_pkg::HWD_IDLE;
			cnt_q   <= 32'h0000_0000;
		end
		else if (evt_q == hwd_pkg::HWD_EVT_OFF)
		begin
			state_q <= hwd_pkg::HWD_IDLE;
			cnt_q   <= period_q;
		end
		else
		begin
			unique case (state_q)
				hwd_pkg::HWD_IDLE:
				begin
					state_q <= hwd_pkg::HWD_RUN;
					cnt_q   <= period_q;
				end
				hwd_pkg::HWD_RUN:
				begin
					if (svc_good)
					begin
						cnt_q <= period_q;
					end
					else if (expire)
					begin
						state_q <= hwd_pkg::HWD_RECOVER;
						cnt_q   <= RECOVER_CYC - 32'd1;
					end
					else
					begin
						cnt_q <= cnt_q - 32'd1;
					end
				end
				hwd_pkg::HWD_RECOVER:
				begin
					if (svc_good || cnt_q == 32'h0000_0000)
					begin
						state_q <= hwd_pkg::HWD_RUN;
						cnt_q   <= period_q;
					end
					else
					begin
						cnt_q <= cnt_q - 32'd1;
					end
				end
				default:
				begin
					state_q <= hwd_pkg::HWD_IDLE;
				end
			endcase
		end
	end

	// Latched interrupt status; set wins over write-one-to-clear
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_ist
			logic set_i;
			assign set_i = (i == `HWD_IRQ_EXPIRE) ? (expire
				&& evt_q[0]) : svc_bad;
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
					ist_q[i] <= 1'b0;
				else if (set_i)
					ist_q[i] <= 1'b1;
				else if (wr_go && awaddr_q == `HWD_OFS_IRQ_STAT
					&& wstrb_q[0] && wdata_q[i])
					ist_q[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			imask_q <= 2'b00;
		else if (wr_go && awaddr_q == `HWD_OFS_IRQ_MASK && wstrb_q[0])
			imask_q <= wdata_q[1:0];
	end

	// Mask gates only the pin; latch and timer run on
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(ist_q & imask_q);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wdt_reset_req <= 1'b0;
		else
			wdt_reset_req <= expire && evt_q[1];
	end

	// Read channel
	assign rd_go = s_axi_arvalid && s_axi_arready;
	always_comb
	begin
		rd_ok = 1'b1;
		rd_d  = 32'h0000_0000;
		unique case (s_axi_araddr)
			`HWD_OFS_SERVICE:  rd_d = 32'h0000_0000;
			`HWD_OFS_CTRL:     rd_d = {29'h0, safe_q, evt_q};
			`HWD_OFS_PERIOD:   rd_d = period_q;
			`HWD_OFS_STATUS:   rd_d = {29'h0,
				state_q == hwd_pkg::HWD_RECOVER,
				state_q != hwd_pkg::HWD_IDLE, safe_q};
			`HWD_OFS_IRQ_STAT: rd_d = {30'h0, ist_q};
			`HWD_OFS_IRQ_MASK: rd_d = {30'h0, imask_q};
			`HWD_OFS_COUNT:    rd_d = cnt_q;
			default:           rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid
				&& s_axi_arvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_d;
				s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// ---- tb/hwd_properties.sv ----
/*
 Checker for the watchdog bus slave and its outputs.
 Sees only the top ports; bound from the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
module hwd_properties (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        irq,
	input wire logic        wdt_reset_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
		|-> s_axi_rdata == 32'h0000_0000) else $error("error data");
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready long");
	chk_b_code: assert property (s_axi_bvalid
		|-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bad bresp");
	chk_quiet_start: assert property ($rose(resetn)
		|-> !irq && !wdt_reset_req) else $error("active at start");
	// Recovery is at least 8 cycles in every build used here
	chk_pulse_gap: assert property (wdt_reset_req
		|=> !wdt_reset_req [*8]) else $error("pulse too close");
endmodule
`default_nettype wire

// ---- tb/hwd_cpu_model.sv ----
/*
 Processor model: bus master tasks and the service write.
 Assumes one clock shared with the watchdog slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hwd_defs.svh"
module hwd_cpu_model (
	input  wire logic        sys_clk,
	output var logic [7:0]   s_axi_awaddr,
	output var logic         s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var logic [31:0]  s_axi_wdata,
	output var logic [3:0]   s_axi_wstrb,
	output var logic         s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output var logic         s_axi_bready,
	output var logic [7:0]   s_axi_araddr,
	output var logic         s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output var logic         s_axi_rready
);
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] resp);
		logic aw_done;
		logic w_done;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done))
		begin
			@(posedge sys_clk);
			if (!aw_done && s_axi_awready === 1'b1)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge sys_clk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge sys_clk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge sys_clk);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic svc;
		logic [1:0] r;
		wr(`HWD_OFS_SERVICE, `HWD_SERVICE_KEY, r);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_hw_watchdog_two_mode.sv ----
/*
 Self-checking bench for the two-mode watchdog.
 Assumes the processor model and checker in tb/.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hwd_defs.svh"
module tb_hw_watchdog_two_mode;
	localparam logic [31:0] PER = 32'h0000_001E;
	localparam int          REC = 20;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, irq, wdt_reset_req, h;
	int          errors = 0;
	int          checked = 0;
	int          gap;
	always #10 sys_clk = ~sys_clk;
	// Short recovery keeps the run brief
	hwd_watchdog #(.RECOVER_CYC(REC)) uut (.*);
	hwd_cpu_model cpu (.*);
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic seek(input logic rst, input int n, output logic hit);
		hit = 1'b0;
		repeat (n)
		begin
			@(posedge sys_clk);
			if ((rst ? wdt_reset_req : irq) === 1'b1)
				hit = 1'b1;
		end
	endtask
	task automatic results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (2)
			@(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3)
			@(posedge sys_clk);
		cpu.rd(`HWD_OFS_CTRL, v, r);
		check("ctrl rst", v, 32'h0000_0000);
		cpu.rd(`HWD_OFS_PERIOD, v, r);
		check("period rst", v, `HWD_PERIOD_RST);
		cpu.rd(8'h40, v, r);
		check("unmapped", {30'h0, r}, 32'h0000_0002);
		cpu.wr(8'h40, 32'h0000_0000, r);
		check("wr unmapped", {30'h0, r}, 32'h0000_0002);
		cpu.wr(`HWD_OFS_PERIOD, PER, r);
		cpu.wr(`HWD_OFS_IRQ_MASK, 32'h0000_0001, r);
		cpu.wr(`HWD_OFS_CTRL, 32'h0000_0001, r);
		repeat (4)
		begin
			repeat (12)
				@(posedge sys_clk);
			cpu.svc();
		end
		check("serviced", {31'h0, irq}, 32'h0000_0000);
		repeat (14)
			@(posedge sys_clk);
		// Wrong key late in the period must not buy more time
		cpu.wr(`HWD_OFS_SERVICE, 32'h0000_0001, r);
		seek(1'b0, 20, h);
		check("expiry", {31'h0, h}, 32'h0000_0001);
		cpu.rd(`HWD_OFS_IRQ_STAT, v, r);
		check("irq stat", {30'h0, v[1:0]}, 32'h0000_0003);
		repeat (60)
			@(posedge sys_clk);
		check("latched", {31'h0, irq}, 32'h0000_0001);
		cpu.wr(`HWD_OFS_IRQ_MASK, 32'h0000_0000, r);
		repeat (2)
			@(posedge sys_clk);
		check("gated", {31'h0, irq}, 32'h0000_0000);
		cpu.rd(`HWD_OFS_IRQ_STAT, v, r);
		check("kept", {31'h0, v[0]}, 32'h0000_0001);
		cpu.wr(`HWD_OFS_CTRL, 32'h0000_0000, r);
		cpu.wr(`HWD_OFS_IRQ_STAT, 32'h0000_0003, r);
		cpu.wr(`HWD_OFS_IRQ_MASK, 32'h0000_0003, r);
		seek(1'b0, 100, h);
		check("off", {31'h0, h}, 32'h0000_0000);
		cpu.rd(`HWD_OFS_COUNT, v, r);
		check("count off", v, PER);
		cpu.wr(`HWD_OFS_CTRL, 32'h0000_0002, r);
		seek(1'b1, 40, h);
		check("pulse", {31'h0, h}, 32'h0000_0001);
		// Pulse to pulse: recovery, then a full period
		while (wdt_reset_req !== 1'b1)
			@(posedge sys_clk);
		gap = 0;
		do
		begin
			@(posedge sys_clk);
			gap++;
		end
		while (wdt_reset_req !== 1'b1);
		check("gap", 32'(gap), 32'(REC) + PER + 32'd1);
		cpu.wr(`HWD_OFS_CTRL, 32'h0000_0001, r);
		while (irq !== 1'b1)
			@(posedge sys_clk);
		cpu.rd(`HWD_OFS_STATUS, v, r);
		check("recovering", v, 32'h0000_0006);
		cpu.svc();
		cpu.rd(`HWD_OFS_STATUS, v, r);
		check("early end", v, 32'h0000_0002);
		check("still set", {31'h0, irq}, 32'h0000_0001);
		cpu.wr(`HWD_OFS_CTRL, 32'h0000_0005, r);
		cpu.wr(`HWD_OFS_CTRL, 32'h0000_0000, r);
		cpu.wr(`HWD_OFS_PERIOD, 32'h0000_0005, r);
		check("lock resp", {30'h0, r}, 32'h0000_0000);
		cpu.rd(`HWD_OFS_CTRL, v, r);
		check("ctrl lock", {29'h0, v[2:0]}, 32'h0000_0005);
		cpu.rd(`HWD_OFS_PERIOD, v, r);
		check("period lock", v, PER);
		cpu.rd(`HWD_OFS_STATUS, v, r);
		check("safe", {31'h0, v[0]}, 32'h0000_0001);
		results();
	end
	// Tests need about 600 cycles; this allows over fifteen times that
	initial
	begin
		#200000;
		errors++;
		results();
	end
endmodule
bind hwd_watchdog hwd_properties chk (.*);
`default_nettype wire
